// ===== hdl/pdad_datapath.sv
// Purpose: transmit predistortion datapath with tables and capture buffers
// Assumes: samples synchronous to core_clk_i, Avalon-MM slave with waitrequest
// Notes: actuator is sequential, one term at a time; upstream stalls meanwhile
// Contract
// - order: peak reduction, interpolation, actuator, converter
// - two cascaded half-bands give 1x, 2x, 4x
// - each stage passes or doubles; 4x needs both
// - stage enables chosen from rate configuration
// - half-band ripple equal, edges symmetric about quarter-rate
// - first stage passes about 82 percent
// - second stage passes about 41 percent
// - predistortion covers carriers up to 200 MHz
// - output sums coef times magnitude power times sample
// - coefficients complex, complex products with samples
// - sparse model, up to 190 active terms
// - 31 nonzero table ids, all reading the one 256-entry table of the selected bank
// - 1k table entries, four banks of 256
// - three capture buffers, 4096 samples each
// - observation samples readable by processor

`timescale 1ns/100ps

module pdad_datapath
  import pdad_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic tx_valid_i,
  input wire pdad_iq_type tx_data_i,
  output logic tx_ready_o,
  input wire logic obs_valid_i,
  input wire pdad_iq_type obs_data_i,
  output logic dac_valid_o,
  output pdad_iq_type dac_data_o,
  input wire logic dac_ready_i
);
  typedef enum logic [2:0] {ACT_IDLE, ACT_FETCH, ACT_LOAD, ACT_POWER, ACT_MAC, ACT_EMIT}
    pdad_act_type;

  // ==========================================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================================
  // control registers
  logic pr_en;
  logic hb1_en;
  logic hb2_en;
  logic act_en;
  logic [1:0] bank_sel;
  logic [TERM_IDX_W-1:0] num_terms;
  logic [15:0] clip_level;
  logic [CAP_LEN_W-1:0] cap_len;
  logic [CAP_BUFS-1:0] cap_done;
  logic [CAP_BUFS-1:0] cap_busy;
  logic [1:0] act_bank;
  logic [TERM_IDX_W-1:0] act_terms;
  pdad_act_type act_state;

  // ==========================================================================
  // bus decode
  logic rd_phase;
  logic [3:0] region;
  logic csr_hit;
  logic term_hit;
  logic lut_hit;
  logic cap_hit;
  logic [1:0] cap_sel;
  logic [TERM_IDX_W-1:0] bus_term_idx;
  logic term_idx_ok;
  logic table_write_ok;
  logic wr_go;
  logic wr_done;
  logic tbl_wr;
  logic wr_full;
  logic wr_ctrl;
  logic wr_clip;
  logic wr_cap;
  logic wr_term_a;
  logic wr_term_b;
  logic wr_lut;
  logic [31:0] status_word;
  logic [31:0] csr_rd;
  logic [31:0] rd_mux;

  assign region = avs_address_i[15:12];
  assign csr_hit = (region == REGION_CSR);
  assign term_hit = (region == REGION_TERM);
  assign lut_hit = (region == REGION_LUT);
  assign cap_sel = avs_address_i[15:14];
  assign cap_hit = (cap_sel != 2'h0);
  assign bus_term_idx = avs_address_i[9:2];
  assign term_idx_ok = (bus_term_idx < TERM_IDX_W'(MAX_TERMS));
  assign table_write_ok = (act_state == ACT_IDLE);
  assign wr_full = (avs_byteenable_i == 4'hf);
  assign tbl_wr = avs_write_i && (term_hit || lut_hit);
  assign wr_go = avs_write_i && avs_waitrequest_o && !(tbl_wr && !table_write_ok);
  // a write lands only at the edge that sees waitrequest low
  assign wr_done = avs_write_i && !avs_waitrequest_o && wr_full;
  assign wr_ctrl = wr_done && csr_hit && (avs_address_i[11:0] == OFS_CTRL[11:0]);
  assign wr_clip = wr_done && csr_hit && (avs_address_i[11:0] == OFS_CLIP[11:0]);
  assign wr_cap = wr_done && csr_hit && (avs_address_i[11:0] == OFS_CAP[11:0]);
  assign wr_term_a = wr_done && term_hit && term_idx_ok && !avs_address_i[TERM_COEF_BIT];
  assign wr_term_b = wr_done && term_hit && term_idx_ok && avs_address_i[TERM_COEF_BIT];
  assign wr_lut = wr_done && lut_hit;

  // ==========================================================================
  // bus handshake: writes answer after one wait cycle, table writes only once the actuator is idle, reads after two
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
      rd_phase <= 1'b0;
    end else if (!avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b1;
      rd_phase <= 1'b0;
    end else if (avs_read_i && rd_phase) begin
      avs_readdata_o <= rd_mux;
      avs_waitrequest_o <= 1'b0;
    end else if (avs_read_i) begin
      rd_phase <= 1'b1;
    end else if (wr_go) begin
      avs_waitrequest_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {pr_en, hb1_en, hb2_en, act_en} <= 4'h0;
      bank_sel <= 2'h0;
      num_terms <= '0;
      clip_level <= CLIP_RESET;
      cap_len <= CAP_LEN_RESET;
    end else if (wr_ctrl) begin
      pr_en <= avs_writedata_i[CTRL_PR_BIT];
      hb1_en <= avs_writedata_i[CTRL_HB1_BIT];
      hb2_en <= avs_writedata_i[CTRL_HB2_BIT];
      act_en <= avs_writedata_i[CTRL_ACT_BIT];
      bank_sel <= avs_writedata_i[CTRL_BANK_LSB +: 2];
      num_terms <= (avs_writedata_i[CTRL_TERMS_LSB +: TERM_IDX_W] > TERM_IDX_W'(MAX_TERMS)) ?
        TERM_IDX_W'(MAX_TERMS) : avs_writedata_i[CTRL_TERMS_LSB +: TERM_IDX_W];
    end else if (wr_clip) begin
      clip_level <= avs_writedata_i[15:0];
    end else if (wr_cap) begin
      cap_len <= (avs_writedata_i[CAP_LEN_LSB +: CAP_LEN_W] == '0 ||
        avs_writedata_i[CAP_LEN_LSB +: CAP_LEN_W] > CAP_LEN_RESET) ?
        CAP_LEN_RESET : avs_writedata_i[CAP_LEN_LSB +: CAP_LEN_W];
    end
  end

  // ==========================================================================
  // peak reduction: hard clip of each component
  logic pr_valid;
  pdad_iq_type pr_data;
  logic hb1_ready;
  logic tx_take;
  logic signed [15:0] clip_pos;
  pdad_iq_type clipped;

  assign clip_pos = $signed({1'b0, clip_level[14:0]});
  assign tx_take = tx_valid_i && tx_ready_o;
  assign clipped.i = !pr_en ? tx_data_i.i : (tx_data_i.i > clip_pos) ? clip_pos :
    (tx_data_i.i < -clip_pos) ? -clip_pos : tx_data_i.i;
  assign clipped.q = !pr_en ? tx_data_i.q : (tx_data_i.q > clip_pos) ? clip_pos :
    (tx_data_i.q < -clip_pos) ? -clip_pos : tx_data_i.q;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pr_valid <= 1'b0;
      pr_data <= '0;
      tx_ready_o <= 1'b0;
    end else begin
      if (tx_take) begin
        pr_valid <= 1'b1;
        pr_data <= clipped;
      end else if (hb1_ready) begin
        pr_valid <= 1'b0;
      end
      tx_ready_o <= !(tx_take || (pr_valid && !hb1_ready));
    end
  end

  // ==========================================================================
  // interpolation chain
  logic hb1_valid;
  pdad_iq_type hb1_data;
  logic hb2_ready;
  logic hb2_valid;
  pdad_iq_type hb2_data;
  logic act_take;

  pdad_halfband #(.NHALF(HB1_NHALF), .COEF(HB1_COEF)) u_first_halfband_stage (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .enable_i(hb1_en),
    .in_valid_i(pr_valid),
    .in_data_i(pr_data),
    .in_ready_o(hb1_ready),
    .out_valid_o(hb1_valid),
    .out_data_o(hb1_data),
    .out_ready_i(hb2_ready)
  );

  pdad_halfband #(.NHALF(HB2_NHALF), .COEF(HB2_COEF)) u_second_halfband_stage (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .enable_i(hb2_en),
    .in_valid_i(hb1_valid),
    .in_data_i(hb1_data),
    .in_ready_o(hb2_ready),
    .out_valid_o(hb2_valid),
    .out_data_o(hb2_data),
    .out_ready_i(act_take)
  );

  // ==========================================================================
  // coefficient and table memories
  logic [31:0] term_a_mem [MAX_TERMS];
  logic [31:0] term_b_mem [MAX_TERMS];
  logic signed [15:0] lut_mem [LUT_TOTAL];
  logic [TERM_IDX_W-1:0] term_idx;
  logic [31:0] term_a_q;
  logic [31:0] term_b_q;
  logic [31:0] bus_term_q;
  logic [15:0] bus_lut_q;
  logic [9:0] lut_addr;
  logic signed [15:0] lut_q;

  always_ff @(posedge core_clk_i) begin
    if (wr_term_a) begin
      term_a_mem[bus_term_idx] <= avs_writedata_i;
    end
    if (wr_term_b) begin
      term_b_mem[bus_term_idx] <= avs_writedata_i;
    end
    if (wr_lut) begin
      lut_mem[avs_address_i[11:2]] <= avs_writedata_i[15:0];
    end
    term_a_q <= term_a_mem[term_idx];
    term_b_q <= term_b_mem[term_idx];
    lut_q <= lut_mem[lut_addr];
    bus_term_q <= avs_address_i[TERM_COEF_BIT] ? term_b_mem[bus_term_idx] :
      term_a_mem[bus_term_idx];
    bus_lut_q <= lut_mem[avs_address_i[11:2]];
  end

  // ==========================================================================
  // actuator arithmetic
  pdad_iq_type hist [HIST_DEPTH];
  logic [3:0] sel_i;
  logic [3:0] sel_j;
  logic [3:0] pow_cnt;
  logic [LUT_ID_W-1:0] lut_id;
  logic signed [15:0] coef_re;
  logic signed [15:0] coef_im;
  logic [15:0] pow_val;
  logic signed [27:0] acc_i;
  logic signed [27:0] acc_q;
  logic [15:0] abs_i;
  logic [15:0] abs_q;
  logic [16:0] mag_raw;
  logic [14:0] mag;
  logic [31:0] pow_prod;
  logic signed [15:0] gain;
  logic signed [31:0] cs_re;
  logic signed [31:0] cs_im;
  logic signed [33:0] w_i;
  logic signed [33:0] w_q;
  logic signed [39:0] t_re;
  logic signed [39:0] t_im;
  logic act_bypass;

  // magnitude estimate: larger plus half the smaller component
  assign abs_i = hist[sel_i].i[15] ? 16'(-hist[sel_i].i) : 16'(hist[sel_i].i);
  assign abs_q = hist[sel_i].q[15] ? 16'(-hist[sel_i].q) : 16'(hist[sel_i].q);
  assign mag_raw = (abs_i > abs_q) ? 17'(abs_i) + 17'(abs_q >> 1) : 17'(abs_q) + 17'(abs_i >> 1);
  assign mag = (mag_raw > 17'(ONE_Q15)) ? ONE_Q15[14:0] : mag_raw[14:0];
  assign pow_prod = 32'(pow_val) * 32'(mag);
  assign lut_addr = {act_bank, mag[14:7]};
  assign gain = (lut_id == '0) ? ONE_Q14 : lut_q;
  assign cs_re = (32'(coef_re) * 32'(gain)) >>> COEF_SHIFT;
  assign cs_im = (32'(coef_im) * 32'(gain)) >>> COEF_SHIFT;
  assign w_i = (34'(hist[sel_j].i) * 34'($signed({1'b0, pow_val}))) >>> SAMPLE_SHIFT;
  assign w_q = (34'(hist[sel_j].q) * 34'($signed({1'b0, pow_val}))) >>> SAMPLE_SHIFT;
  assign t_re = (40'(cs_re) * 40'(w_i) - 40'(cs_im) * 40'(w_q)) >>> COEF_SHIFT;
  assign t_im = (40'(cs_re) * 40'(w_q) + 40'(cs_im) * 40'(w_i)) >>> COEF_SHIFT;
  assign act_bypass = !act_en || (num_terms == '0);
  // no sample enters while a table write is pending or landing
  assign act_take = hb2_valid && (act_state == ACT_IDLE) && !tbl_wr;

  // ==========================================================================
  // actuator sequencer, one term per pass
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      act_state <= ACT_IDLE;
      hist <= '{default: '0};
      {sel_i, sel_j, pow_cnt} <= 12'h000;
      {lut_id, coef_re, coef_im} <= '0;
      pow_val <= '0;
      {acc_i, acc_q} <= '0;
      term_idx <= '0;
      act_bank <= 2'h0;
      act_terms <= '0;
      dac_valid_o <= 1'b0;
      dac_data_o <= '0;
    end else begin
      if (dac_ready_i) begin
        dac_valid_o <= 1'b0;
      end
      unique case (act_state)
        ACT_IDLE: begin
          if (act_take) begin
            hist[0] <= hb2_data;
            for (int n = 1; n < HIST_DEPTH; n++) begin
              hist[n] <= hist[n-1];
            end
            act_bank <= bank_sel;
            act_terms <= num_terms;
            term_idx <= '0;
            acc_i <= act_bypass ? 28'(hb2_data.i) : '0;
            acc_q <= act_bypass ? 28'(hb2_data.q) : '0;
            act_state <= act_bypass ? ACT_EMIT : ACT_FETCH;
          end
        end
        ACT_FETCH: begin
          act_state <= ACT_LOAD;
        end
        ACT_LOAD: begin
          sel_i <= term_a_q[TERM_I_LSB +: 4];
          sel_j <= term_a_q[TERM_J_LSB +: 4];
          pow_cnt <= term_a_q[TERM_K_LSB +: 4];
          lut_id <= term_a_q[TERM_LUT_LSB +: LUT_ID_W];
          coef_re <= term_b_q[15:0];
          coef_im <= term_b_q[31:16];
          pow_val <= ONE_Q15;
          act_state <= ACT_POWER;
        end
        ACT_POWER: begin
          if (pow_cnt != 4'h0) begin
            pow_val <= pow_prod[30:15];
            pow_cnt <= pow_cnt - 4'h1;
          end else begin
            act_state <= ACT_MAC;
          end
        end
        ACT_MAC: begin
          acc_i <= acc_i + t_re[27:0];
          acc_q <= acc_q + t_im[27:0];
          term_idx <= term_idx + 8'h01;
          act_state <= (term_idx + 8'h01 == act_terms) ? ACT_EMIT : ACT_FETCH;
        end
        ACT_EMIT: begin
          if (!dac_valid_o || dac_ready_i) begin
            dac_valid_o <= 1'b1;
            dac_data_o.i <= pdad_sat16(40'(acc_i));
            dac_data_o.q <= pdad_sat16(40'(acc_q));
            act_state <= ACT_IDLE;
          end
        end
        default: act_state <= ACT_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // capture buffers: actuator input, actuator output, observation
  logic [CAP_BUFS-1:0] cap_valid;
  logic [31:0] cap_word [CAP_BUFS];
  logic [31:0] cap_q [CAP_BUFS];
  logic cap_start;

  assign cap_start = wr_cap && avs_writedata_i[CAP_START_BIT];
  assign cap_valid[0] = act_take;
  assign cap_word[0] = hb2_data;
  assign cap_valid[1] = (act_state == ACT_EMIT) && (!dac_valid_o || dac_ready_i);
  assign cap_word[1] = {pdad_sat16(40'(acc_q)), pdad_sat16(40'(acc_i))};
  assign cap_valid[2] = obs_valid_i;
  assign cap_word[2] = obs_data_i;

  genvar b;
  generate
    for (b = 0; b < CAP_BUFS; b++) begin : g_cap
      logic [31:0] cap_mem [CAP_DEPTH];
      logic [CAP_LEN_W-1:0] cap_ptr;
      always_ff @(posedge core_clk_i) begin
        if (cap_busy[b] && cap_valid[b]) begin
          cap_mem[cap_ptr[11:0]] <= cap_word[b];
        end
        cap_q[b] <= cap_mem[avs_address_i[13:2]];
      end
      always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          cap_ptr <= '0;
          cap_busy[b] <= 1'b0;
          cap_done[b] <= 1'b0;
        end else if (cap_busy[b] && cap_valid[b] && (cap_ptr + 13'h0001 == cap_len)) begin
          cap_busy[b] <= 1'b0;
          cap_done[b] <= 1'b1;
        end else if (cap_start) begin
          cap_ptr <= '0;
          cap_busy[b] <= 1'b1;
          cap_done[b] <= 1'b0;
        end else if (cap_busy[b] && cap_valid[b]) begin
          cap_ptr <= cap_ptr + 13'h0001;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read selection
  always_comb begin
    status_word = '0;
    status_word[STAT_DONE_LSB +: CAP_BUFS] = cap_done;
    status_word[STAT_BUSY_LSB +: CAP_BUFS] = cap_busy;
    status_word[STAT_ACT_BIT] = (act_state != ACT_IDLE);
    status_word[STAT_TERMS_LSB +: TERM_IDX_W] = act_terms;
    status_word[STAT_BANK_LSB +: 2] = act_bank;
  end

  assign csr_rd =
    (avs_address_i[11:0] == OFS_CTRL[11:0]) ? {16'h0000, num_terms, 2'h0, bank_sel, act_en,
      hb2_en, hb1_en, pr_en} :
    (avs_address_i[11:0] == OFS_STATUS[11:0]) ? status_word :
    (avs_address_i[11:0] == OFS_CLIP[11:0]) ? {16'h0000, clip_level} :
    (avs_address_i[11:0] == OFS_CAP[11:0]) ? {3'h0, cap_len, 16'h0000} : 32'h00000000;
  assign rd_mux = cap_hit ? cap_q[cap_sel - 2'h1] :
    csr_hit ? csr_rd :
    (term_hit && term_idx_ok) ? bus_term_q :
    lut_hit ? {{16{bus_lut_q[15]}}, bus_lut_q} : 32'h00000000;
endmodule

// ===== hdl/pdad_halfband.sv
// Purpose: shared types and constants, and the half-band interpolate-by-two stage
// Assumes: one clock, asynchronous active-low reset from the top, released synchronously
// Notes: a stage either passes samples unchanged or emits two outputs per input

package pdad_pkg;
  // ==========================================================================
  // sample format
  typedef struct packed {
    logic signed [15:0] q;
    logic signed [15:0] i;
  } pdad_iq_type;

  // ==========================================================================
  // actuator and table geometry
  localparam int MAX_TERMS = 190;
  localparam int TERM_IDX_W = 8;
  localparam int HIST_DEPTH = 16;
  localparam int LUT_BANKS = 4;
  localparam int LUT_ENTRIES = 256;
  localparam int LUT_TOTAL = LUT_BANKS * LUT_ENTRIES;
  localparam int LUT_ID_W = 5;
  localparam int CAP_DEPTH = 4096;
  localparam int CAP_BUFS = 3;
  localparam int CAP_LEN_W = 13;

  // ==========================================================================
  // register map, byte addresses
  localparam logic [15:0] OFS_CTRL = 16'h0000;
  localparam logic [15:0] OFS_STATUS = 16'h0004;
  localparam logic [15:0] OFS_CLIP = 16'h0008;
  localparam logic [15:0] OFS_CAP = 16'h000c;
  localparam logic [3:0] REGION_CSR = 4'h0;
  localparam logic [3:0] REGION_TERM = 4'h1;
  localparam logic [3:0] REGION_LUT = 4'h2;
  localparam int TERM_COEF_BIT = 10;

  // ctrl fields
  localparam int CTRL_PR_BIT = 0;
  localparam int CTRL_HB1_BIT = 1;
  localparam int CTRL_HB2_BIT = 2;
  localparam int CTRL_ACT_BIT = 3;
  localparam int CTRL_BANK_LSB = 4;
  localparam int CTRL_TERMS_LSB = 8;
  // term word fields
  localparam int TERM_I_LSB = 0;
  localparam int TERM_J_LSB = 4;
  localparam int TERM_K_LSB = 8;
  localparam int TERM_LUT_LSB = 16;
  // status fields
  localparam int STAT_DONE_LSB = 0;
  localparam int STAT_BUSY_LSB = 3;
  localparam int STAT_ACT_BIT = 6;
  localparam int STAT_TERMS_LSB = 8;
  localparam int STAT_BANK_LSB = 16;
  // capture control fields
  localparam int CAP_START_BIT = 0;
  localparam int CAP_LEN_LSB = 16;

  // ==========================================================================
  // reset values and fixed-point scaling
  localparam logic [15:0] CLIP_RESET = 16'h7fff;
  localparam logic [12:0] CAP_LEN_RESET = 13'h1000;
  localparam logic [15:0] ONE_Q15 = 16'h7fff;
  localparam logic signed [15:0] ONE_Q14 = 16'sh4000;
  localparam int COEF_SHIFT = 14;
  localparam int SAMPLE_SHIFT = 15;
  localparam int HB_SHIFT = 15;

  // ==========================================================================
  // half-band odd-phase taps, outermost first, each half sums to one half
  localparam int HB1_NHALF = 4;
  localparam int HB1_COEF [HB1_NHALF] = '{-80, 784, -3920, 19600};
  localparam int HB2_NHALF = 2;
  localparam int HB2_COEF [HB2_NHALF] = '{-2048, 18432};

  function automatic logic signed [15:0] pdad_sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007fff) begin
      return 16'sh7fff;
    end else if (v < -40'sh0000008000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction
endpackage

`timescale 1ns/100ps

module pdad_halfband
  import pdad_pkg::*;
#(
  parameter int NHALF = HB2_NHALF,
  parameter int COEF [NHALF] = HB2_COEF
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic in_valid_i,
  input wire pdad_iq_type in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output pdad_iq_type out_data_o,
  input wire logic out_ready_i
);
  localparam int NTAP = 2 * NHALF;

  generate
    if (NHALF < 1 || NHALF > 8) begin : g_bad
      $error("half-band length out of range");
    end
  endgenerate

  pdad_iq_type taps [NTAP];
  pdad_iq_type odd_sample;
  logic odd_pending;
  logic signed [39:0] prod_i [NHALF];
  logic signed [39:0] prod_q [NHALF];
  logic signed [39:0] sum_i;
  logic signed [39:0] sum_q;

  // ==========================================================================
  // symmetric odd-phase products
  genvar m;
  generate
    for (m = 0; m < NHALF; m++) begin : g_tap
      assign prod_i[m] = 40'(COEF[m]) * (40'(taps[m].i) + 40'(taps[NTAP-1-m].i));
      assign prod_q[m] = 40'(COEF[m]) * (40'(taps[m].q) + 40'(taps[NTAP-1-m].q));
    end
  endgenerate

  always_comb begin
    sum_i = '0;
    sum_q = '0;
    for (int n = 0; n < NHALF; n++) begin
      sum_i = sum_i + prod_i[n];
      sum_q = sum_q + prod_q[n];
    end
  end

  assign odd_sample.i = pdad_sat16(sum_i >>> HB_SHIFT);
  assign odd_sample.q = pdad_sat16(sum_q >>> HB_SHIFT);
  assign in_ready_o = !odd_pending && (!out_valid_o || out_ready_i);

  // ==========================================================================
  // even phase is the delayed input, odd phase the filtered midpoint
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      taps <= '{default: '0};
      odd_pending <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (in_valid_i && in_ready_o) begin
      taps[0] <= in_data_i;
      for (int n = 1; n < NTAP; n++) begin
        taps[n] <= taps[n-1];
      end
      out_data_o <= enable_i ? taps[NHALF-1] : in_data_i;
      odd_pending <= enable_i;
      out_valid_o <= 1'b1;
    end else if (odd_pending && (!out_valid_o || out_ready_i)) begin
      out_data_o <= odd_sample;
      odd_pending <= 1'b0;
      out_valid_o <= 1'b1;
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

// ===== verif/pdad_dac_sink.sv
// Purpose: converter-side sink model
// Assumes: shares the datapath clock
// Notes: random stalls while enabled
`timescale 1ns/100ps
module pdad_dac_sink (
  input wire logic core_clk_i,
  input wire logic stall_en_i,
  output logic dac_ready_o = 1'b0
);
  always @(posedge core_clk_i) dac_ready_o <= !stall_en_i || $urandom_range(1);
endmodule

// ===== verif/pdad_datapath_asserts.sv
// Purpose: port assertions for pdad_datapath
// Assumes: bus and stream timing of the hand-over
// Notes: bound below the module
`timescale 1ns/100ps
module pdad_checker
  import pdad_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic dac_valid_o,
  input wire pdad_iq_type dac_data_o,
  input wire logic dac_ready_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire req = avs_read_i || avs_write_i;
  wire wr_wait = avs_write_i && avs_waitrequest_o;
  wire stall = dac_valid_o && !dac_ready_i;
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer held");
  a_wait_cause: assert property ($fell(avs_waitrequest_o) |-> $past(req))
    else $error("answer without request");
  a_read_two: assert property ($rose(avs_read_i) |-> avs_waitrequest_o [*2] ##1 !avs_waitrequest_o)
    else $error("read latency");
  a_csr_write: assert property (wr_wait && avs_address_i[15:12] == 4'h0 |=> !avs_waitrequest_o)
    else $error("control write late");
  a_tbl_bound: assert property (wr_wait && avs_address_i[15:12] != 4'h0 |-> ##[1:1000] !avs_waitrequest_o)
    else $error("table write stuck");
  a_out_hold: assert property (stall |=> dac_valid_o)
    else $error("valid dropped");
  a_out_stable: assert property (stall |=> $stable(dac_data_o))
    else $error("data moved");
  a_in_space: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o)
    else $error("ready twice");
  c_read: cover property ($rose(avs_read_i));
  c_stall: cover property (stall);
  c_take: cover property (tx_valid_i && tx_ready_o);
endmodule
bind pdad_datapath pdad_checker u_pdad_checker (.*);

// ===== verif/pdad_datapath_tb.sv
// Purpose: self-checking bench for the predistortion datapath
// Assumes: bench plays coefficient processor and sample source
// Notes: driver queues expected samples, monitor compares
`timescale 1ns/100ps
module predistortion_actuator_datapath_tb_top;
  import pdad_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, txv = 1'b0, stall = 1'b0, cmp = 1'b0;
  logic wq, rdy, dv, dr;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wd = 32'h0, msk = 32'hffff_ffff, rdat, rdo;
  logic [3:0] be = 4'hf;
  pdad_iq_type txd = 32'h0, dd, s, x, s0, x0, q[$];
  int fails = 0, n_checks = 0, n_out = 0, cyc = 0, f[4] = '{1, 2, 2, 4};
  always #4 clk = ~clk;
  pdad_datapath u_pdad_datapath (.core_clk_i(clk), .resetn_i(rstn), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wq), .tx_valid_i(txv), .tx_data_i(txd),
    .tx_ready_o(rdy), .obs_valid_i(txv), .obs_data_i(txd), .dac_valid_o(dv),
    .dac_data_o(dd), .dac_ready_i(dr));
  pdad_dac_sink u_pdad_dac_sink (.core_clk_i(clk), .stall_en_i(stall), .dac_ready_o(dr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    if (seen !== exp) fails++;
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic send(input pdad_iq_type v, input pdad_iq_type x);
    if (cmp) q.push_back(x);
    @(posedge clk);
    txv <= 1'b1;
    txd <= v;
    do @(posedge clk); while (rdy !== 1'b1);
    txv <= 1'b0;
    txd <= ~v;
  endtask
  task automatic drain(input int n);
    for (int t = 0; t < 3000 && n_out < n; t++) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      fails++;
      end_of_test();
    end
    if (dv === 1'b1 && dr === 1'b1) begin
      n_out++;
      if (cmp) check(dd & msk, q.pop_front() & msk);
    end
  end
  initial begin
    void'($urandom(93));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    be <= 4'h3;
    bus(1'b1, OFS_CLIP, 32'h0000_1234);
    be <= 4'hf;
    bus(1'b0, OFS_CLIP, 32'h0);
    check(rdat, {16'h0000, CLIP_RESET});
    bus(1'b0, 16'h0010, 32'h0);
    check(rdat, 32'h0);
    $display("register test done");
    cmp = 1'b1;
    stall <= 1'b1;
    bus(1'b1, OFS_CLIP, 32'h0000_1000);
    bus(1'b1, OFS_CAP, 32'h0008_0001);
    bus(1'b1, OFS_CTRL, 32'(1 << CTRL_PR_BIT));
    for (int k = 0; k < 8; k++) begin
      s = $urandom;
      x = s;
      if (s.i > 16'sh1000) x.i = 16'sh1000;
      if (s.i < -16'sh1000) x.i = -16'sh1000;
      if (s.q > 16'sh1000) x.q = 16'sh1000;
      if (s.q < -16'sh1000) x.q = -16'sh1000;
      if (k == 0) s0 = s;
      if (k == 0) x0 = x;
      send(s, x);
    end
    drain(8);
    bus(1'b0, OFS_STATUS, 32'h0);
    check(rdat, 32'h0000_0007);
    bus(1'b0, 16'h4000, 32'h0);
    check(rdat, x0);
    bus(1'b0, 16'h8000, 32'h0);
    check(rdat, x0);
    bus(1'b0, 16'hc000, 32'h0);
    check(rdat, s0);
    $display("bypass test done");
    cmp = 1'b0;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFS_CTRL, 32'(m << CTRL_HB1_BIT));
      n_out = 0;
      repeat (4) send($urandom, 32'h0);
      drain(4 * f[m]);
      check(n_out, 4 * f[m]);
    end
    $display("interpolation test done");
    bus(1'b1, 16'h1000, 32'h0);
    bus(1'b1, 16'h1400, 32'h4000_0000);
    bus(1'b1, OFS_CTRL, 32'h0000_0108);
    cmp = 1'b1;
    msk = 32'hfffc_fffc;
    n_out = 0;
    repeat (6) begin
      s = ($urandom & 32'hbffc_bffc) | 32'h0002_0002;
      send(s, {s.i, -s.q});
    end
    drain(6);
    $display("actuator test done");
    end_of_test();
  end
endmodule
